// [bench/interrupt_state_save_and_vectoring_tb.sv]
// Self-checking testbench of the interrupt state save and vectoring block.
`timescale 1ns/1ns

module interrupt_state_save_and_vectoring_tb;
   logic                clock;
   logic                rstn;
   logic                retCrit;
   logic                retMc;
   isv_pkg::isv_event_t evt;
   isv_pkg::isv_move_t  move;
   logic [4:0]          readSel;
   logic [31:0]         readData;
   logic [31:0]         stateReg;
   logic                redirect;
   logic [31:0]         fetchAddr;
   logic                critEnable;
   int                  miscompares;
   int                  nChecks;
   logic [4:0]          s;

   isv_pipe_model u_model (.clock(clock), .evt(evt));
   isv_core u_isv_core (.clock(clock), .rstn(rstn), .evt(evt), .retCrit(retCrit),
      .retMc(retMc), .move(move), .readSel(readSel), .readData(readData),
      .stateReg(stateReg), .redirect(redirect), .fetchAddr(fetchAddr),
      .critEnable(critEnable));

   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] sel, input logic [31:0] data);
      move = '{write: 1'h1, sel: sel, data: data};
      @(posedge clock);
      #1 move.write = 1'h0;
      // One idle edge keeps a following write from raising the strobe it just lowered.
      @(posedge clock);
      #1;
   endtask

   task automatic rd(input logic [4:0] sel, input logic [31:0] exp);
      readSel = sel;
      @(posedge clock);
      #1 chk(readData, exp);
   endtask

   task automatic ret(input logic mc);
      if (mc) retMc = 1'h1;
      else retCrit = 1'h1;
      @(posedge clock);
      #1 retMc = 1'h0;
      retCrit = 1'h0;
   endtask

   task automatic print_verdict;
      if (miscompares == 0 && nChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   initial begin
      #20000;
      miscompares++;
      print_verdict;
   end

   initial begin
      miscompares = 0;
      nChecks     = 0;
      rstn        = 1'h0;
      retCrit     = 1'h0;
      retMc       = 1'h0;
      move        = '0;
      readSel     = 5'h00;
      repeat (16) @(posedge clock);
      #1 rstn = 1'h1;
      // Machine state is clear after reset, so both gated types must be dropped.
      for (int g = 0; g < 2; g++) begin
         u_model.fire(g ? isv_pkg::INT_WATCHDOG : isv_pkg::INT_CRIT_INPUT, 32'h0, 32'h0, 32'h0);
         chk(32'(redirect), 32'h0);
         @(posedge clock);
         #1;
      end
      for (int i = 0; i < 22; i++) begin
         s = (i < 6) ? 5'(i) : 5'(i + 10);
         rd(s, isv_pkg::RESET_VALUE);
         wr(s, 32'hFFFFFFFF);
         rd(s, (i >= 6) ? isv_pkg::OFFSET_MASK : (s == isv_pkg::SR_MC_RETURN) ?
            isv_pkg::RETURN_ADDR_MASK : (s == isv_pkg::SR_PREFIX) ? isv_pkg::PREFIX_MASK :
            32'hFFFFFFFF);
      end
      wr(5'h06, 32'hFFFFFFFF);
      rd(5'h06, 32'h00000000);
      wr(isv_pkg::SR_PREFIX, 32'hABCD1234);
      for (int k = 0; k < 16; k++) wr(isv_pkg::SR_OFFSET_BASE + 5'(k), 32'hFFFF005F | (k << 8));
      wr(isv_pkg::SR_MC_SAVED, 32'h0002A5A5);
      wr(isv_pkg::SR_MC_RETURN, 32'h00400103);
      ret(1'h1);
      chk(stateReg, 32'h0002A5A5);
      chk(fetchAddr, 32'h00400100);
      chk(32'(redirect), 32'h1);
      chk(32'(critEnable), 32'h1);
      u_model.fire(isv_pkg::INT_MACH_CHECK, 32'h00800007, 32'h0, 32'h80000000);
      chk(stateReg, 32'h00000000);
      chk(32'(critEnable), 32'h0);
      chk(fetchAddr, 32'hABCD0150);
      rd(isv_pkg::SR_MC_SAVED, 32'h0002A5A5);
      rd(isv_pkg::SR_MC_RETURN, 32'h00800004);
      rd(isv_pkg::SR_SYNDROME, 32'h80000000);
      u_model.fire(isv_pkg::INT_PROGRAM, 32'h0, 32'h0, 32'h08000000);
      rd(isv_pkg::SR_SYNDROME, 32'h08000000);
      u_model.fire(isv_pkg::INT_PROGRAM, 32'h0, 32'h0, 32'h06000000);
      rd(isv_pkg::SR_SYNDROME, 32'h06000000);
      u_model.fire(isv_pkg::INT_SYS_CALL, 32'h0, 32'h0, 32'h01000000);
      rd(isv_pkg::SR_SYNDROME, 32'h06000000);
      u_model.fire(isv_pkg::INT_ALIGNMENT, 32'h0, 32'h12345677, 32'h0);
      rd(isv_pkg::SR_DATA_FAULT, 32'h12345677);
      wr(isv_pkg::SR_CRIT_SAVED, 32'h0002F00F);
      ret(1'h0);
      chk(stateReg, 32'h0002F00F);
      wr(isv_pkg::SR_CRIT_SAVED, 32'h00000000);
      u_model.fire(isv_pkg::INT_CRIT_INPUT, 32'h0, 32'h0, 32'h0);
      rd(isv_pkg::SR_CRIT_SAVED, 32'h0002F00F);
      for (int k = 0; k < 16; k++) begin
         ret(1'h0);
         u_model.fire(isv_pkg::isv_int_t'(k[3:0]), 32'h0, 32'h0, 32'h0);
         chk(32'(redirect), 32'h1);
         chk(fetchAddr, 32'hABCD0050 | (k << 8));
      end
      print_verdict;
   end
endmodule

// [bench/isv_pipe_model.sv]
// Behavioural model of the pipeline and exception detection that feed the block.
`timescale 1ns/1ns

module isv_pipe_model (
   input  wire logic           clock, // Core clock.
   output isv_pkg::isv_event_t evt    // Interrupt event towards the block.
);
   // ************************************************************
   // Event issue
   // ************************************************************
   initial begin
      evt = '0;
   end

   // Idle fields are inverted after each pulse so that a stale value is never trusted.
   task automatic fire(input isv_pkg::isv_int_t kind, input logic [31:0] ra,
                       input logic [31:0] da, input logic [31:0] syn);
      isv_pkg::isv_event_t req;
      req.take       = 1'h1;
      req.kind       = kind;
      req.returnAddr = ra;
      req.dataAddr   = da;
      req.dataFault  = kind inside {isv_pkg::INT_ALIGNMENT, isv_pkg::INT_DATA_STOR,
                                    isv_pkg::INT_DATA_XLATE};
      req.synWrite   = kind inside {isv_pkg::INT_MACH_CHECK, isv_pkg::INT_DATA_STOR,
                                    isv_pkg::INT_INSTR_STOR, isv_pkg::INT_ALIGNMENT,
                                    isv_pkg::INT_PROGRAM, isv_pkg::INT_DATA_XLATE};
      req.synValue   = syn;
      evt            = req;
      @(posedge clock);
      #1;
      req      = isv_pkg::isv_event_t'(~req);
      req.take = 1'h0;
      evt      = req;
   endtask
endmodule

// [hw/isv_core.sv]
// Interrupt state save, restore and vector formation logic.
// Function
// - Critical interrupt copies pre-interrupt machine state into critical saved state.
// - Critical return loads machine state from critical saved state.
// - Reserved saved-state bits are stored and may be restored as written.
// - Machine check writes the return address of the interrupted process.
// - Machine-check return redirects fetch to the saved return address.
// - Return address bits 0..29 kept, bits 30..31 reserved as zero.
// - Machine check saves pre-interrupt machine state before clearing it.
// - Machine-check return restores machine state from machine-check saved state.
// - Faulting data address captured on alignment, translation miss, storage faults.
// - Vector is prefix 0..15, offset 16..27, four zero bits.
// - Sixteen offset registers, one selected per interrupt type.
// - Prefix supplies upper 16 bits; reserved prefix and offset bits zero.
// - Syndrome-using interrupts set the cause bits and clear all others.
// - Other interrupt types leave the syndrome unchanged.
// - Syndrome bit 0 marks fetch machine check; bits 1..3 reserved.
// - Program syndrome bits 4, 5, 6: illegal, privileged, trap.
// - Every register but machine state writable and readable by special register moves.
// - Machine-state bit 14 gates critical input and watchdog interrupts.
`timescale 1ns/1ns

module isv_core (
   input  wire logic               clock,      // Core clock.
   input  wire logic               rstn,       // Asynchronous reset, low.
   input  wire isv_pkg::isv_event_t evt,       // Interrupt event from detection.
   input  wire logic               retCrit,    // Return-from-critical executes.
   input  wire logic               retMc,      // Return-from-machine-check executes.
   input  wire isv_pkg::isv_move_t move,       // Move-to special register.
   input  wire logic [4:0]         readSel,    // Move-from register number.
   output logic [31:0]             readData,   // Move-from data, registered.
   output logic [31:0]             stateReg,   // Machine state register.
   output logic                    redirect,   // Fetch redirect pulse.
   output logic [31:0]             fetchAddr,  // Redirect target.
   output logic                    critEnable  // Critical interrupts enabled.
);

   isv_pkg::isv_state_t st;
   isv_pkg::isv_state_t next_st;
   logic                accept;

   // ************************************************************
   // Helpers.
   // ************************************************************
   function automatic logic [31:0] vectorOf(input logic [31:0] pre,
                                            input logic [31:0] off);
      vectorOf = (pre & isv_pkg::PREFIX_MASK) | (off & isv_pkg::OFFSET_MASK);
   endfunction

   function automatic logic isCritClass(input isv_pkg::isv_int_t k);
      isCritClass = (k == isv_pkg::INT_CRIT_INPUT) || (k == isv_pkg::INT_WATCHDOG)
                    || (k == isv_pkg::INT_DEBUG);
   endfunction

   // Types that the critical enable bit of the machine state can hold off.
   function automatic logic isGated(input isv_pkg::isv_int_t k);
      isGated = (k == isv_pkg::INT_CRIT_INPUT) || (k == isv_pkg::INT_WATCHDOG);
   endfunction

   // Critical input and watchdog are dropped while the enable bit is clear.
   always_comb begin
      accept = evt.take;
      if (isGated(evt.kind) && !st.stateReg[isv_pkg::CRIT_ENABLE_POS]) begin
         accept = 1'b0;
      end
   end

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      next_st          = st;
      next_st.redirect = 1'b0;
      // Register moves come first so that a same-cycle interrupt save wins.
      if (move.write) begin
         unique case (move.sel)
            isv_pkg::SR_CRIT_SAVED: next_st.critSaved = move.data;
            isv_pkg::SR_MC_RETURN:
               next_st.mcReturn = move.data & isv_pkg::RETURN_ADDR_MASK;
            isv_pkg::SR_MC_SAVED:   next_st.mcSaved   = move.data;
            isv_pkg::SR_DATA_FAULT: next_st.dataFault = move.data;
            isv_pkg::SR_PREFIX:
               next_st.prefix = move.data & isv_pkg::PREFIX_MASK;
            isv_pkg::SR_SYNDROME:   next_st.syndrome  = move.data & isv_pkg::SYNDROME_MASK;
            default: begin
               if (move.sel[4]) begin
                  next_st.offset[move.sel[3:0]] = move.data & isv_pkg::OFFSET_MASK;
               end
            end
         endcase
      end
      if (accept) begin
         if (isCritClass(evt.kind)) begin
            next_st.critSaved = st.stateReg;
         end
         if (evt.kind == isv_pkg::INT_MACH_CHECK) begin
            next_st.mcSaved  = st.stateReg;
            next_st.mcReturn = evt.returnAddr & isv_pkg::RETURN_ADDR_MASK;
         end
         if (evt.dataFault && (evt.kind == isv_pkg::INT_ALIGNMENT
             || evt.kind == isv_pkg::INT_DATA_STOR || evt.kind == isv_pkg::INT_DATA_XLATE)) begin
            next_st.dataFault = evt.dataAddr;
         end
         if (evt.synWrite) begin
            // Whole-word load clears every bit the cause does not name.
            next_st.syndrome = evt.synValue;
         end
         next_st.stateReg  = isv_pkg::RESET_VALUE;
         next_st.redirect  = 1'b1;
         next_st.fetchAddr = vectorOf(st.prefix, st.offset[evt.kind]);
      end else if (retMc) begin
         next_st.stateReg  = st.mcSaved;
         next_st.redirect  = 1'b1;
         next_st.fetchAddr = st.mcReturn;
      end else if (retCrit) begin
         next_st.stateReg = st.critSaved;
      end
      next_st.readData = isv_pkg::RESET_VALUE;
      unique case (readSel)
         isv_pkg::SR_CRIT_SAVED: next_st.readData = st.critSaved;
         isv_pkg::SR_MC_RETURN:  next_st.readData = st.mcReturn;
         isv_pkg::SR_MC_SAVED:   next_st.readData = st.mcSaved;
         isv_pkg::SR_DATA_FAULT: next_st.readData = st.dataFault;
         isv_pkg::SR_PREFIX:     next_st.readData = st.prefix;
         isv_pkg::SR_SYNDROME:   next_st.readData = st.syndrome;
         default: begin
            if (readSel[4]) begin
               next_st.readData = st.offset[readSel[3:0]];
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign readData   = st.readData;
   assign stateReg   = st.stateReg;
   assign redirect   = st.redirect;
   assign fetchAddr  = st.fetchAddr;
   assign critEnable = st.stateReg[isv_pkg::CRIT_ENABLE_POS];

   // ************************************************************
   // Checks.
   // ************************************************************
   crit_save_a: assert property (@(posedge clock) disable iff (!rstn)
      (accept && isCritClass(evt.kind)) |=> (st.critSaved == $past(st.stateReg)))
      else $error("critical saved state not captured");
   mc_save_a: assert property (@(posedge clock) disable iff (!rstn)
      (accept && evt.kind == isv_pkg::INT_MACH_CHECK) |=>
      (st.mcSaved == $past(st.stateReg) && st.stateReg == 32'h00000000))
      else $error("machine check state not saved");
   mc_return_a: assert property (@(posedge clock) disable iff (!rstn)
      (!accept && retMc) |=> (redirect && fetchAddr == $past(st.mcReturn)))
      else $error("machine check return target wrong");
   mc_restore_a: assert property (@(posedge clock) disable iff (!rstn)
      (!accept && retMc) |=> (stateReg == $past(st.mcSaved)))
      else $error("machine state not restored");
   crit_restore_a: assert property (@(posedge clock) disable iff (!rstn)
      (!accept && !retMc && retCrit) |=> (stateReg == $past(st.critSaved)))
      else $error("critical restore wrong");
   ret_align_a: assert property (@(posedge clock) disable iff (!rstn)
      st.mcReturn[1:0] == 2'h0)
      else $error("return address reserved bits set");
   vector_form_a: assert property (@(posedge clock) disable iff (!rstn)
      accept |=> (fetchAddr[31:16] == $past(st.prefix[31:16]) && fetchAddr[3:0] == 4'h0
      && fetchAddr[15:4] == $past(st.offset[evt.kind][15:4]) && redirect))
      else $error("vector address malformed");
   syn_keep_a: assert property (@(posedge clock) disable iff (!rstn)
      (accept && !evt.synWrite && !(move.write && move.sel == isv_pkg::SR_SYNDROME))
      |=> $stable(st.syndrome))
      else $error("syndrome changed by non-syndrome interrupt");
   crit_gate_a: assert property (@(posedge clock) disable iff (!rstn)
      (evt.take && isGated(evt.kind) && !critEnable && !retMc) |=> !redirect)
      else $error("gated interrupt taken while disabled");
   fault_addr_a: assert property (@(posedge clock) disable iff (!rstn)
      (accept && evt.dataFault && evt.kind == isv_pkg::INT_ALIGNMENT)
      |=> st.dataFault == $past(evt.dataAddr))
      else $error("data fault address missed");
   mc_retaddr_a: assert property (@(posedge clock) disable iff (!rstn)
      (accept && evt.kind == isv_pkg::INT_MACH_CHECK)
      |=> st.mcReturn == ($past(evt.returnAddr) & isv_pkg::RETURN_ADDR_MASK))
      else $error("machine check return address not saved");
   syn_load_a: assert property (@(posedge clock) disable iff (!rstn)
      (accept && evt.synWrite) |=> st.syndrome == $past(evt.synValue))
      else $error("syndrome not loaded for cause");
   quiet_fetch_a: assert property (@(posedge clock) disable iff (!rstn)
      (!accept && !retMc) |=> !redirect)
      else $error("redirect without interrupt or return");
   prefix_read_a: assert property (@(posedge clock) disable iff (!rstn)
      (readSel == isv_pkg::SR_PREFIX) |=> readData == $past(st.prefix))
      else $error("prefix read back wrong");
   prefix_res_a: assert property (@(posedge clock) disable iff (!rstn)
      (st.prefix & ~isv_pkg::PREFIX_MASK) == 32'h00000000)
      else $error("prefix reserved bits set");

   // Reserved offset fields must stay clear, or a vector could leave its 16-byte slot.
   for (genvar n = 0; n < 16; n++) begin : g_offset_check
      offset_res_a: assert property (@(posedge clock) disable iff (!rstn)
         (st.offset[n] & ~isv_pkg::OFFSET_MASK) == 32'h00000000)
         else $error("offset reserved bits set");
   end

endmodule

// [hw/isv_pkg.sv]
// Package for the interrupt state save and vectoring block.
package isv_pkg;

   // ************************************************************
   // Special register numbers (coined, move-to/move-from select).
   // ************************************************************
   localparam logic [4:0] SR_CRIT_SAVED   = 5'h00;
   localparam logic [4:0] SR_MC_RETURN    = 5'h01;
   localparam logic [4:0] SR_MC_SAVED     = 5'h02;
   localparam logic [4:0] SR_DATA_FAULT   = 5'h03;
   localparam logic [4:0] SR_PREFIX       = 5'h04;
   localparam logic [4:0] SR_SYNDROME     = 5'h05;
   localparam logic [4:0] SR_OFFSET_BASE  = 5'h10;

   // ************************************************************
   // Field layouts, big-endian bit 0 is the MSB (index 31).
   // ************************************************************
   localparam logic [31:0] RETURN_ADDR_MASK = 32'hFFFFFFFC;
   localparam logic [31:0] PREFIX_MASK      = 32'hFFFF0000;
   localparam logic [31:0] OFFSET_MASK      = 32'h0000FFF0;
   localparam logic [31:0] SYNDROME_MASK    = 32'hFFFFFFFF;
   localparam int          CRIT_ENABLE_POS  = 17;
   localparam int          SYN_FETCH_MC     = 31;
   localparam int          SYN_ILLEGAL      = 27;
   localparam int          SYN_PRIVILEGED   = 26;
   localparam int          SYN_TRAP         = 25;
   localparam logic [31:0] RESET_VALUE      = 32'h00000000;

   // ************************************************************
   // Interrupt types in offset-register index order.
   // ************************************************************
   typedef enum logic [3:0] {
      INT_CRIT_INPUT  = 4'h0,
      INT_MACH_CHECK  = 4'h1,
      INT_DATA_STOR   = 4'h2,
      INT_INSTR_STOR  = 4'h3,
      INT_EXT_INPUT   = 4'h4,
      INT_ALIGNMENT   = 4'h5,
      INT_PROGRAM     = 4'h6,
      INT_FPU_UNAVAIL = 4'h7,
      INT_SYS_CALL    = 4'h8,
      INT_AUX_UNAVAIL = 4'h9,
      INT_DECREMENTER = 4'hA,
      INT_FIXED_INTV  = 4'hB,
      INT_WATCHDOG    = 4'hC,
      INT_DATA_XLATE  = 4'hD,
      INT_INSTR_XLATE = 4'hE,
      INT_DEBUG       = 4'hF
   } isv_int_t;

   typedef struct packed {
      logic        take;        // Interrupt taken this cycle.
      isv_int_t    kind;        // Interrupt type.
      logic [31:0] returnAddr;  // Address tied to interrupted process.
      logic [31:0] dataAddr;    // Faulting data address.
      logic        dataFault;   // Data address is valid for capture.
      logic        synWrite;    // This type updates the syndrome.
      logic [31:0] synValue;    // Syndrome bits for the cause.
   } isv_event_t;

   typedef struct packed {
      logic        write;       // Move-to-special-register.
      logic [4:0]  sel;         // Register number.
      logic [31:0] data;        // Write data.
   } isv_move_t;

   typedef struct packed {
      logic [31:0]       critSaved;
      logic [31:0]       mcReturn;
      logic [31:0]       mcSaved;
      logic [31:0]       dataFault;
      logic [31:0]       prefix;
      logic [31:0]       syndrome;
      logic [15:0][31:0] offset;
      logic [31:0]       stateReg;
      logic              redirect;
      logic [31:0]       fetchAddr;
      logic [31:0]       readData;
   } isv_state_t;

endpackage
